// file: sim/field_switches.sv
// Purpose: field switches and sensors wired to the digital inputs
// Assumes: contacts are already debounced by the sensor side
// Notes:   voltage is present exactly while a contact is closed
`timescale 1ns/1ps

module field_switches #(
    parameter int N = 4
) (
    input  wire logic [N-1:0] closed, // contact states from the bench
    output logic      [N-1:0] din     // voltage seen at the inputs
);
    assign din = closed;
endmodule : field_switches

// file: sim/testbench.sv
// Purpose: self-checking bench for the motor starter input actions
// Assumes: inputs change at the falling edge, outputs registered
// Notes:   pulses are counted at rising edges, levels after settling
`timescale 1ns/1ps
`include "motor_input_defines.svh"
`define CHK(g, e) chk(8'(g), 8'(e))

module testbench;
    logic clk, arst_n, ml, bcw, bccw, bbr, itrip, sprot, gf, trst, qsd;
    logic mcur, qsa, rpls, ctrip, crun, bapp;
    logic [3:0] sw, din, rej;
    motor_input_pkg::input_cfg_t cfg [4];
    motor_input_pkg::drive_t     drv;
    int mismatches, num_checks, rcnt, bcnt, cyc;

    field_switches #(.N(4)) sensors (.closed(sw), .din(din));
    motor_starter_input_actions #(.N(4)) DUT (
        .clk(clk), .arst_n(arst_n), .din(din), .cfg(cfg),
        .manual_local(ml), .bus_cw(bcw), .bus_ccw(bccw), .bus_brake(bbr),
        .int_trip(itrip), .self_prot(sprot), .group_fault(gf),
        .trip_reset(trst), .qs_disable(qsd), .main_current(mcur),
        .drive(drv), .qs_active(qsa), .trip_rst_pls(rpls),
        .cold_trip(ctrip), .cold_run(crun), .brake_apply(bapp),
        .cfg_reject(rej));

    initial
    begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end

    // pulse counters and hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (rpls === 1'h1) rcnt++;
        if (bapp === 1'h1) bcnt++;
        if (cyc >= 3000)
        begin
            mismatches++;
            finish_test();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step

    task automatic setc(input int i, input logic [3:0] a, input logic nc,
                        input logic r);
        cfg[i] = '{action: a, level_nc: nc, retentive: r};
    endtask : setc

    task automatic t_dir();
        for (int d = 0; d < 2; d++)
        begin
            setc(0, d ? `MIA_ACT_CCW : `MIA_ACT_CW, 1'h0, 1'h0);
            ml = 1'h1; sw[0] = 1'h1; bcnt = 0; step(4);
            `CHK(drv, d ? 3'h3 : 3'h5);
            `CHK(bcnt, 1);
            sw[0] = 1'h0; step(3);
            `CHK(drv, 3'h0);
        end
        ml = 1'h0; sw[0] = 1'h1; step(4);
        `CHK(drv, 3'h0);
        sw[0] = 1'h0; ml = 1'h1; setc(0, `MIA_ACT_CW, 1'h0, 1'h1); step(2);
        sw[0] = 1'h1; step(1); sw[0] = 1'h0; step(4);
        `CHK(drv, 3'h5);
        gf = 1'h1; step(3); gf = 1'h0; step(2);
        `CHK(drv, 3'h0);
        $display("test direction done");
    endtask : t_dir

    task automatic t_qs();
        setc(0, `MIA_ACT_CW, 1'h0, 1'h0); setc(1, `MIA_ACT_QSTOP, 1'h0, 1'h1);
        sw[0] = 1'h1; step(3); sw[1] = 1'h1; step(4);
        `CHK(drv, 3'h0);
        `CHK(qsa, 1'h1);
        trst = 1'h1; step(1); trst = 1'h0; step(4);
        `CHK(qsa, 1'h0);
        sw[1] = 1'h0; step(2); sw[1] = 1'h1; step(4);
        `CHK(qsa, 1'h1);
        qsd = 1'h1; step(4);
        `CHK(qsa, 1'h0);
        `CHK(drv, 3'h5);
        sw[1] = 1'h0; step(2); sw[1] = 1'h1; step(4);
        `CHK(drv, 3'h5);
        qsd = 1'h0; sw[1] = 1'h0; step(2); sw[1] = 1'h1; step(4);
        sw[0] = 1'h0; step(4);
        `CHK(qsa, 1'h0);
        sw[1] = 1'h0; setc(1, `MIA_ACT_QSTOP, 1'h0, 1'h0);
        sw[0] = 1'h1; step(3); sw[1] = 1'h1; step(4);
        `CHK(drv, 3'h0);
        sw[1] = 1'h0; step(4);
        `CHK(drv, 3'h5);
        sw[0] = 1'h0; step(3);
        $display("test quick stop done");
    endtask : t_qs

    task automatic t_trst();
        setc(2, `MIA_ACT_TRIPRST, 1'h0, 1'h0); rcnt = 0;
        sw[2] = 1'h1; step(6);
        `CHK(rcnt, 1);
        sw[2] = 1'h0; rcnt = 0;
        setc(2, `MIA_ACT_TRIPRST, 1'h1, 1'h0); step(3);
        `CHK(rej[2], 1'h1);
        sw[2] = 1'h1; step(2); sw[2] = 1'h0; step(5);
        `CHK(rcnt, 0);
        sw[2] = 1'h0; setc(2, `MIA_ACT_NONE, 1'h0, 1'h0);
        $display("test trip reset done");
    endtask : t_trst

    task automatic t_estart();
        setc(3, `MIA_ACT_ESTART, 1'h0, 1'h0);
        ml = 1'h0; bcw = 1'h1; bbr = 1'h1; itrip = 1'h1; step(3);
        `CHK(drv, 3'h0);
        sw[3] = 1'h1; step(4);
        `CHK(drv, 3'h5);
        sprot = 1'h1; step(3);
        `CHK(drv, 3'h0);
        sprot = 1'h0; itrip = 1'h0; bcw = 1'h0; bbr = 1'h0; sw[3] = 1'h0;
        setc(3, `MIA_ACT_ESTART, 1'h1, 1'h0); step(3);
        `CHK(rej[3], 1'h1);
        itrip = 1'h1; bcw = 1'h1; step(3);
        `CHK(drv, 3'h0);
        itrip = 1'h0; bcw = 1'h0;
        setc(3, `MIA_ACT_COLDRUN, 1'h0, 1'h0); sw[3] = 1'h1; step(3);
        `CHK(crun, 1'h1);
        `CHK(ctrip, 1'h0);
        mcur = 1'h1; step(3);
        `CHK(ctrip, 1'h1);
        mcur = 1'h0; sw[3] = 1'h0; trst = 1'h1; step(1); trst = 1'h0;
        $display("test emergency start and cold run done");
    endtask : t_estart

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test

    initial
    begin
        {arst_n, ml, bcw, bccw, bbr, itrip, sprot} = 7'h0;
        {gf, trst, qsd, mcur, sw} = 8'h0;
        {mismatches, num_checks, rcnt, bcnt, cyc} = '0;
        for (int i = 0; i < 4; i++)
            setc(i, `MIA_ACT_NONE, 1'h0, 1'h0);
        step(4);
        arst_n = 1'h1;
        step(2);
        t_dir();
        t_qs();
        t_trst();
        t_estart();
        finish_test();
    end
endmodule : testbench

// file: verilog/motor_input_defines.svh
// Purpose: constants for the motor starter input-action block
// Assumes: inputs already debounced and synchronous to clk
// Notes:   the action codes are the encoding of the per-input action field
//
// Behaviour
// - emergency start overrides internal trip on ON
// - emergency start also lets brake switch on
// - self-protection trips always stay effective
// - estart and direction actions need NO logic
// - direction actions only in manual local mode
// - direction switching applies braking parameters
// - direction action switches motor and brake together
// - retentive direction latch cleared by stop/fault
// - quick stop switches motor, brake off, no fault
// - quick stop beats both direction commands
// - retentive quick stop latches; reset releases it
// - quick stop cleared by commands gone or disable
// - disable bit masks new quick-stop edges
// - after disable clears stop, motor restarts in the commanded direction
// - non-retentive stop holds off, restart on release
// - trip reset gives one pulse per activation
// - trip reset only with NO input logic
// - cold run trips if main current flows
// - non-retentive action follows input level; trip reset acts on the edge
// - actions of all inputs are OR-combined
// - retentive direction and quick stop actions stay latched until cleared
`ifndef MOTOR_INPUT_DEFINES_SVH
`define MOTOR_INPUT_DEFINES_SVH

`define MIA_N_INPUTS      4
`define MIA_ACT_W         4
`define MIA_ACT_NONE      4'h0
`define MIA_ACT_ESTART    4'h7
`define MIA_ACT_CW        4'h8
`define MIA_ACT_CCW       4'h9
`define MIA_ACT_QSTOP     4'ha
`define MIA_ACT_TRIPRST   4'hb
`define MIA_ACT_COLDRUN   4'hc
`define MIA_RST_BIT       1'h0

`endif

// file: verilog/motor_input_pkg.sv
// Purpose: types shared by the input-action block
// Assumes: constants come from motor_input_defines.svh
// Notes:   one config word per digital input
`include "motor_input_defines.svh"

package motor_input_pkg;

    typedef struct packed {
        logic [`MIA_ACT_W-1:0] action;     // action code
        logic                  level_nc;   // 1 = normally closed
        logic                  retentive;  // 1 = edge latched
    } input_cfg_t;

    typedef struct packed {
        logic motor_cw;   // motor clockwise enable
        logic motor_ccw;  // motor counter-clockwise enable
        logic brake;      // brake output enable
    } drive_t;

endpackage : motor_input_pkg

// file: verilog/motor_starter_input_actions.sv
// Purpose: maps debounced digital inputs to motor starter actions
// Assumes: inputs debounced and synchronous to clk
// Notes:   all outputs registered; quick stop has top priority
`timescale 1ns/1ps
`include "motor_input_defines.svh"

module motor_starter_input_actions #(
    parameter int N = `MIA_N_INPUTS
) (
    input  wire logic                          clk,          // 250 MHz
    input  wire logic                          arst_n,       // async reset
    input  wire logic [N-1:0]                  din,          // raw inputs
    input  motor_input_pkg::input_cfg_t        cfg [N],      // per input
    input  wire logic                          manual_local, // local mode
    input  wire logic                          bus_cw,       // fieldbus CW
    input  wire logic                          bus_ccw,      // fieldbus CCW
    input  wire logic                          bus_brake,    // brake ON cmd
    input  wire logic                          int_trip,     // internal trip
    input  wire logic                          self_prot,    // self-protect
    input  wire logic                          group_fault,  // group fault
    input  wire logic                          trip_reset,   // reset cmd
    input  wire logic                          qs_disable,   // from image
    input  wire logic                          main_current, // current seen
    output motor_input_pkg::drive_t            drive,        // enables
    output logic                               qs_active,    // stop held
    output logic                               trip_rst_pls, // reset event
    output logic                               cold_trip,    // cold run trip
    output logic                               cold_run,     // no-power run
    output logic                               brake_apply,  // braking event
    output logic [N-1:0]                       cfg_reject    // bad level cfg
);

    // ------------------------------------------------------------------
    // input decode
    // ------------------------------------------------------------------
    logic [N-1:0] act_lvl;
    logic [N-1:0] act_ok;
    logic [N-1:0] prev_reg;
    logic [N-1:0] prev_next;
    logic [N-1:0] rise;

    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            act_lvl[i] = din[i] ^ cfg[i].level_nc;
            // only quick stop may run with normally closed logic
            act_ok[i]  = !(cfg[i].level_nc &&
                           (cfg[i].action == `MIA_ACT_ESTART  ||
                            cfg[i].action == `MIA_ACT_CW      ||
                            cfg[i].action == `MIA_ACT_CCW     ||
                            cfg[i].action == `MIA_ACT_TRIPRST ||
                            cfg[i].action == `MIA_ACT_COLDRUN));
        end
        prev_next = act_lvl;
        rise      = act_lvl & ~prev_reg & act_ok;
    end

    // ------------------------------------------------------------------
    // per-action combination
    // ------------------------------------------------------------------
    logic [N-1:0] cw_lat_reg, cw_lat_next;
    logic [N-1:0] ccw_lat_reg, ccw_lat_next;
    logic         qs_lat_reg, qs_lat_next;
    logic         estart, in_cw, in_ccw, qs_lvl, qs_edge, tr_edge, cold_act;
    logic         cmd_cw, cmd_ccw, trip_any, qs_now;
    logic         cold_trip_next, cold_run_next, qs_next;
    logic         trip_rst_next, brake_apply_next;
    logic [N-1:0] cfg_reject_next;
    motor_input_pkg::drive_t drive_next;

    always_comb
    begin
        estart   = 1'b0;
        in_cw    = 1'b0;
        in_ccw   = 1'b0;
        qs_lvl   = 1'b0;
        qs_edge  = 1'b0;
        tr_edge  = 1'b0;
        cold_act = 1'b0;
        for (int i = 0; i < N; i++)
        begin
            unique case (cfg[i].action)
                `MIA_ACT_ESTART:  estart   |= act_lvl[i] & act_ok[i];
                `MIA_ACT_CW:      in_cw    |= cfg[i].retentive ?
                                              cw_lat_reg[i] :
                                              act_lvl[i] & act_ok[i];
                `MIA_ACT_CCW:     in_ccw   |= cfg[i].retentive ?
                                              ccw_lat_reg[i] :
                                              act_lvl[i] & act_ok[i];
                `MIA_ACT_QSTOP:
                begin
                    if (cfg[i].retentive)
                        qs_edge |= rise[i];
                    else
                        qs_lvl  |= act_lvl[i];
                end
                `MIA_ACT_TRIPRST: tr_edge  |= rise[i];
                `MIA_ACT_COLDRUN: cold_act |= act_lvl[i] & act_ok[i];
                default:          ;
            endcase
        end
        // direction actions are ignored outside manual local mode
        in_cw  = in_cw & manual_local;
        in_ccw = in_ccw & manual_local;
        cmd_cw  = manual_local ? in_cw  : bus_cw;
        cmd_ccw = manual_local ? in_ccw : bus_ccw;
    end

    // ------------------------------------------------------------------
    // retentive latches
    // ------------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            cw_lat_next[i]  = cw_lat_reg[i];
            ccw_lat_next[i] = ccw_lat_reg[i];
            if (qs_active || group_fault)
            begin
                cw_lat_next[i]  = 1'b0;
                ccw_lat_next[i] = 1'b0;
            end
            else if (cfg[i].retentive && rise[i])
            begin
                // latch held regardless of later level
                if (cfg[i].action == `MIA_ACT_CW)
                    cw_lat_next[i] = 1'b1;
                if (cfg[i].action == `MIA_ACT_CCW)
                    ccw_lat_next[i] = 1'b1;
            end
        end
        qs_lat_next = qs_lat_reg;
        if (qs_disable || trip_reset || !(cmd_cw || cmd_ccw))
            qs_lat_next = 1'b0;
        if (qs_edge && !qs_disable)
            qs_lat_next = 1'b1;
        // non-retentive stop is also lifted by the disable bit
        qs_now  = qs_lat_next | (qs_lvl & ~qs_disable);
        qs_next = qs_now;
    end

    // ------------------------------------------------------------------
    // drive enables
    // ------------------------------------------------------------------
    always_comb
    begin
        // emergency start masks internal trip, never self-protection
        trip_any = (int_trip & ~estart) | self_prot | cold_trip;
        cold_run_next  = cold_act;
        cold_trip_next = (cold_trip & ~trip_reset) |
                         (cold_act & main_current);
        drive_next.motor_cw  = cmd_cw & ~cmd_ccw & ~qs_now &
                               ~trip_any;
        drive_next.motor_ccw = cmd_ccw & ~cmd_cw & ~qs_now &
                               ~trip_any;
        // local direction actions switch the brake with the motor
        drive_next.brake = (bus_brake | in_cw | in_ccw) & ~qs_now &
                           ~trip_any;
        trip_rst_next    = tr_edge;
        brake_apply_next = manual_local &&
                           ((drive_next.motor_cw  != drive.motor_cw) ||
                            (drive_next.motor_ccw != drive.motor_ccw));
        for (int i = 0; i < N; i++)
            cfg_reject_next[i] = ~act_ok[i];
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prev_reg     <= '0;
            cw_lat_reg   <= '0;
            ccw_lat_reg  <= '0;
            qs_lat_reg   <= `MIA_RST_BIT;
            qs_active    <= `MIA_RST_BIT;
            drive        <= '0;
            trip_rst_pls <= `MIA_RST_BIT;
            cold_trip    <= `MIA_RST_BIT;
            cold_run     <= `MIA_RST_BIT;
            brake_apply  <= `MIA_RST_BIT;
            cfg_reject   <= '0;
        end
        else
        begin
            prev_reg     <= prev_next;
            cw_lat_reg   <= cw_lat_next;
            ccw_lat_reg  <= ccw_lat_next;
            qs_lat_reg   <= qs_lat_next;
            qs_active    <= qs_next;
            drive        <= drive_next;
            trip_rst_pls <= trip_rst_next;
            cold_trip    <= cold_trip_next;
            cold_run     <= cold_run_next;
            brake_apply  <= brake_apply_next;
            cfg_reject   <= cfg_reject_next;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    qs_blocks_motor_a: assert property (
        qs_active |-> !drive.motor_cw && !drive.motor_ccw && !drive.brake)
        else $error("motor enabled during quick stop");

    dir_exclusive_a: assert property (
        !(drive.motor_cw && drive.motor_ccw))
        else $error("both directions enabled");

    self_prot_a: assert property (
        self_prot |=> !drive.motor_cw && !drive.motor_ccw && !drive.brake)
        else $error("self protection overridden");

    estart_a: assert property (
        estart && int_trip && !self_prot && !cold_trip && !qs_now &&
        !manual_local && bus_cw && !bus_ccw |=> drive.motor_cw)
        else $error("emergency start did not start motor");

    trip_blocks_a: assert property (
        int_trip && !estart |=> !drive.motor_cw && !drive.motor_ccw)
        else $error("internal trip ignored");

    tr_single_a: assert property (
        trip_rst_pls |=> !trip_rst_pls)
        else $error("trip reset pulse longer than one cycle");

    qs_disable_a: assert property (
        qs_disable |=> !qs_active)
        else $error("quick stop active despite disable");

    cold_trip_a: assert property (
        cold_act && main_current |=> cold_trip)
        else $error("cold run current did not trip");

    auto_dir_a: assert property (
        !manual_local && !bus_cw |=> !drive.motor_cw)
        else $error("input direction acted outside manual mode");

    qs_release_a: assert property (
        qs_lat_reg && !cmd_cw && !cmd_ccw && !qs_edge |=> !qs_lat_reg)
        else $error("quick stop not released on command removal");

    restart_a: assert property (
        qs_active && qs_disable && cmd_cw && !cmd_ccw && !trip_any ##1
        qs_disable && cmd_cw && !cmd_ccw && !trip_any |=> drive.motor_cw)
        else $error("motor did not restart after disable");

    estart_brake_a: assert property (
        estart && bus_brake && !self_prot && !cold_trip && !qs_now |=>
        drive.brake)
        else $error("emergency start did not switch the brake");

    dir_brake_a: assert property (
        manual_local && cmd_cw && !cmd_ccw && !qs_now && !trip_any |=>
        drive.motor_cw && drive.brake)
        else $error("clockwise action did not switch motor and brake");

    dir_off_a: assert property (
        manual_local && !in_cw && !in_ccw && !bus_brake |=>
        !drive.motor_cw && !drive.motor_ccw && !drive.brake)
        else $error("direction release left motor or brake on");

    brake_pulse_a: assert property (
        manual_local && (drive_next.motor_cw != drive.motor_cw) |=>
        brake_apply)
        else $error("direction change gave no braking event");

    qs_level_a: assert property (
        qs_lvl && !qs_disable |=> qs_active)
        else $error("level quick stop not in force");

    qs_latch_a: assert property (
        qs_edge && !qs_disable |=> qs_active)
        else $error("quick stop edge not latched");

    tr_event_a: assert property (
        tr_edge |=> trip_rst_pls)
        else $error("trip reset edge gave no event");

    latch_clear_a: assert property (
        group_fault |=> !(|cw_lat_reg) && !(|ccw_lat_reg))
        else $error("group fault left a direction latch set");

    cold_clear_a: assert property (
        cold_trip && trip_reset && !(cold_act && main_current) |=>
        !cold_trip)
        else $error("cold run trip not cleared by reset");

    // ------------------------------------------------------------------
    // cover points
    // ------------------------------------------------------------------
    cover_qs_c: cover property (drive.motor_cw ##1 qs_active);
    cover_cold_c: cover property (cold_trip);
    cover_restart_c: cover property (qs_active ##[1:4] drive.motor_cw);
    cover_estart_c: cover property (estart && int_trip && drive.motor_cw);
    cover_tr_c: cover property (trip_rst_pls);

endmodule : motor_starter_input_actions
